// >>> common/cmo_pkg.sv
// ============================================================
package cmo_pkg;

	// ============================================================
	// Register map, byte addresses of each write-only word
	localparam logic [31:0] CMO_ICACHE_INVALIDATE_ALL_ADDR = 32'he000ef50;
	localparam logic [31:0] CMO_RESERVED_ADDR = 32'he000ef54;
	localparam logic [31:0] CMO_ICACHE_INVALIDATE_BY_ADDR_ADDR = 32'he000ef58;
	localparam logic [31:0] CMO_DCACHE_INVALIDATE_BY_ADDR_ADDR = 32'he000ef5c;
	localparam logic [31:0] CMO_DCACHE_INVALIDATE_BY_SETWAY_ADDR = 32'he000ef60;
	localparam logic [31:0] CMO_DCACHE_MAINT_ADDR_UNIF_ADDR = 32'he000ef64;
	localparam logic [31:0] CMO_DCACHE_CLEAN_BY_ADDR_ADDR = 32'he000ef68;
	localparam logic [31:0] CMO_DCACHE_CLEAN_BY_SETWAY_ADDR = 32'he000ef6c;
	localparam logic [31:0] CMO_DCACHE_CLEAN_INVALIDATE_BY_ADDR_ADDR = 32'he000ef70;
	localparam logic [31:0] CMO_SPACE_FIRST_ADDR = 32'he000ef50;
	localparam logic [31:0] CMO_SPACE_LAST_ADDR = 32'he000ef73;

	// ============================================================
	// Set/way field layout defaults
	localparam int CMO_LINE_BITS_DEF = 5;
	localparam int CMO_SET_BITS_DEF = 7;
	localparam int CMO_WAY_BITS_DEF = 2;

	// ============================================================
	// Reset values
	localparam logic [31:0] CMO_RDATA_RESET = 32'h0000_0000;
	localparam logic [31:0] CMO_ADDR_RESET = 32'h0000_0000;

	// ============================================================
	// Cache operations handed to the cache controller
	typedef enum logic [3:0] {
		CMO_OP_NONE = 4'h0,
		CMO_OP_IC_INV_ALL = 4'h1,
		CMO_OP_IC_INV_ADDR = 4'h2,
		CMO_OP_DC_INV_ADDR = 4'h3,
		CMO_OP_DC_INV_SW = 4'h4,
		CMO_OP_DC_CLEAN_UNIF = 4'h5,
		CMO_OP_DC_CLEAN_ADDR = 4'h6,
		CMO_OP_DC_CLEAN_SW = 4'h7,
		CMO_OP_DC_CLEAN_INV_ADDR = 4'h8
	} cmo_op_e;

	// ============================================================
	// Access sequencer states
	typedef enum logic [2:0] {
		CMO_ST_IDLE = 3'b001,
		CMO_ST_ISSUE = 3'b010,
		CMO_ST_DONE = 3'b100
	} cmo_state_e;

endpackage

// >>> logic/cmo_decode.sv
`timescale 1ns/1ps
// ============================================================
// Address decoder for the maintenance word space
module cmo_decode (
	input wire logic [31:0] i_addr,
	output logic o_in_space,
	output cmo_pkg::cmo_op_e o_op
);
	logic [31:0] word_addr;

	// Any byte lane of a word selects that word
	assign word_addr = {i_addr[31:2], 2'b00};
	assign o_in_space = (i_addr >= cmo_pkg::CMO_SPACE_FIRST_ADDR) && (i_addr <= cmo_pkg::CMO_SPACE_LAST_ADDR);

	// Word to operation; reserved and foreign words map to none
	always_comb begin
		case (word_addr)
			cmo_pkg::CMO_ICACHE_INVALIDATE_ALL_ADDR: o_op = cmo_pkg::CMO_OP_IC_INV_ALL;
			cmo_pkg::CMO_ICACHE_INVALIDATE_BY_ADDR_ADDR: o_op = cmo_pkg::CMO_OP_IC_INV_ADDR;
			cmo_pkg::CMO_DCACHE_INVALIDATE_BY_ADDR_ADDR: o_op = cmo_pkg::CMO_OP_DC_INV_ADDR;
			cmo_pkg::CMO_DCACHE_INVALIDATE_BY_SETWAY_ADDR: o_op = cmo_pkg::CMO_OP_DC_INV_SW;
			cmo_pkg::CMO_DCACHE_MAINT_ADDR_UNIF_ADDR: o_op = cmo_pkg::CMO_OP_DC_CLEAN_UNIF;
			cmo_pkg::CMO_DCACHE_CLEAN_BY_ADDR_ADDR: o_op = cmo_pkg::CMO_OP_DC_CLEAN_ADDR;
			cmo_pkg::CMO_DCACHE_CLEAN_BY_SETWAY_ADDR: o_op = cmo_pkg::CMO_OP_DC_CLEAN_SW;
			cmo_pkg::CMO_DCACHE_CLEAN_INVALIDATE_BY_ADDR_ADDR: o_op = cmo_pkg::CMO_OP_DC_CLEAN_INV_ADDR;
			default: o_op = cmo_pkg::CMO_OP_NONE;
		endcase
	end
endmodule // cmo_decode

// >>> logic/cmo_top.sv
`timescale 1ns/1ps
// ============================================================
// Cache maintenance register port
module cmo_top #(
	parameter int LINE_BITS = cmo_pkg::CMO_LINE_BITS_DEF,
	parameter int SET_BITS = cmo_pkg::CMO_SET_BITS_DEF,
	parameter int WAY_BITS = cmo_pkg::CMO_WAY_BITS_DEF
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic i_priv,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_op_ready,
	output logic o_ack,
	output logic o_bus_fault,
	output logic [31:0] o_rdata,
	output logic o_op_valid,
	output cmo_pkg::cmo_op_e o_op_code,
	output logic o_op_icache,
	output logic o_op_clean,
	output logic o_op_inval,
	output logic o_op_setway,
	output logic o_op_point_of_unification,
	output logic [31:0] o_op_addr,
	output logic [SET_BITS-1:0] o_op_set,
	output logic [WAY_BITS-1:0] o_op_way
);
	cmo_pkg::cmo_state_e state_q, state_d;
	logic ack_q, ack_d;
	logic fault_q, fault_d;
	logic [31:0] rdata_q, rdata_d;
	logic op_valid_q, op_valid_d;
	cmo_pkg::cmo_op_e code_q, code_d;
	logic icache_q, icache_d;
	logic clean_q, clean_d;
	logic inval_q, inval_d;
	logic setway_q, setway_d;
	logic unif_q, unif_d;
	logic [31:0] addr_q, addr_d;
	logic [SET_BITS-1:0] set_q, set_d;
	logic [WAY_BITS-1:0] way_q, way_d;
	logic in_space;
	cmo_pkg::cmo_op_e dec_op;
	logic take;
	logic [31:0] line_addr;

	// ============================================================
	// Word decode
	cmo_decode u_decode (
		.i_addr(i_addr),
		.o_in_space(in_space),
		.o_op(dec_op)
	);

	// Only one access is in flight; new ones are taken in idle
	assign take = i_req && (state_q == cmo_pkg::CMO_ST_IDLE);
	// Line-aligned target; low bits below a line are meaningless
	assign line_addr = {i_wdata[31:LINE_BITS], LINE_BITS'(0)};

	// ============================================================
	// Sequencer and answer
	always_comb begin
		state_d = state_q;
		ack_d = 1'b0;
		fault_d = 1'b0;
		rdata_d = cmo_pkg::CMO_RDATA_RESET;
		case (state_q)
			cmo_pkg::CMO_ST_IDLE: begin
				if (take) begin
					if (in_space && !i_priv) begin
						state_d = cmo_pkg::CMO_ST_DONE;
						ack_d = 1'b1;
						fault_d = 1'b1;
					end else if (i_write && dec_op != cmo_pkg::CMO_OP_NONE) begin
						state_d = cmo_pkg::CMO_ST_ISSUE;
					end else begin
						// Reads and the reserved word only answer
						state_d = cmo_pkg::CMO_ST_DONE;
						ack_d = 1'b1;
					end
				end
			end
			cmo_pkg::CMO_ST_ISSUE: begin
				// Hold the store until the cache takes the operation
				if (i_op_ready) begin
					state_d = cmo_pkg::CMO_ST_DONE;
					ack_d = 1'b1;
				end
			end
			cmo_pkg::CMO_ST_DONE: begin
				state_d = cmo_pkg::CMO_ST_IDLE;
			end
			default: begin
				state_d = cmo_pkg::CMO_ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			state_q <= cmo_pkg::CMO_ST_IDLE;
			ack_q <= 1'b0;
			fault_q <= 1'b0;
			rdata_q <= cmo_pkg::CMO_RDATA_RESET;
		end else begin
			state_q <= state_d;
			ack_q <= ack_d;
			fault_q <= fault_d;
			rdata_q <= rdata_d;
		end
	end

	// ============================================================
	// Operation command to the cache controller
	always_comb begin
		op_valid_d = op_valid_q;
		code_d = code_q;
		icache_d = icache_q;
		clean_d = clean_q;
		inval_d = inval_q;
		setway_d = setway_q;
		unif_d = unif_q;
		addr_d = addr_q;
		set_d = set_q;
		way_d = way_q;
		if (op_valid_q && i_op_ready) begin
			op_valid_d = 1'b0;
		end
		if (take && i_priv && i_write && dec_op != cmo_pkg::CMO_OP_NONE) begin
			op_valid_d = 1'b1;
			code_d = dec_op;
			addr_d = line_addr;
			set_d = i_wdata[LINE_BITS +: SET_BITS];
			way_d = i_wdata[31 -: WAY_BITS];
			icache_d = 1'b0;
			clean_d = 1'b0;
			inval_d = 1'b0;
			setway_d = 1'b0;
			unif_d = 1'b0;
			case (dec_op)
				cmo_pkg::CMO_OP_IC_INV_ALL: begin
					// Whole cache, so no address is meaningful
					icache_d = 1'b1;
					inval_d = 1'b1;
					unif_d = 1'b1;
					addr_d = cmo_pkg::CMO_ADDR_RESET;
				end
				cmo_pkg::CMO_OP_IC_INV_ADDR: begin
					icache_d = 1'b1;
					inval_d = 1'b1;
					unif_d = 1'b1;
				end
				cmo_pkg::CMO_OP_DC_INV_ADDR: begin
					inval_d = 1'b1;
				end
				cmo_pkg::CMO_OP_DC_INV_SW: begin
					inval_d = 1'b1;
					setway_d = 1'b1;
				end
				cmo_pkg::CMO_OP_DC_CLEAN_UNIF: begin
					clean_d = 1'b1;
					unif_d = 1'b1;
				end
				cmo_pkg::CMO_OP_DC_CLEAN_ADDR: begin
					clean_d = 1'b1;
				end
				cmo_pkg::CMO_OP_DC_CLEAN_SW: begin
					clean_d = 1'b1;
					setway_d = 1'b1;
				end
				cmo_pkg::CMO_OP_DC_CLEAN_INV_ADDR: begin
					clean_d = 1'b1;
					inval_d = 1'b1;
				end
				default: begin
					op_valid_d = 1'b0;
				end
			endcase
		end
	end

	// Command registers
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			op_valid_q <= 1'b0;
			code_q <= cmo_pkg::CMO_OP_NONE;
			icache_q <= 1'b0;
			clean_q <= 1'b0;
			inval_q <= 1'b0;
			setway_q <= 1'b0;
			unif_q <= 1'b0;
			addr_q <= cmo_pkg::CMO_ADDR_RESET;
			set_q <= '0;
			way_q <= '0;
		end else begin
			op_valid_q <= op_valid_d;
			code_q <= code_d;
			icache_q <= icache_d;
			clean_q <= clean_d;
			inval_q <= inval_d;
			setway_q <= setway_d;
			unif_q <= unif_d;
			addr_q <= addr_d;
			set_q <= set_d;
			way_q <= way_d;
		end
	end

	// ============================================================
	// Outputs straight from flops
	assign o_ack = ack_q;
	assign o_bus_fault = fault_q;
	assign o_rdata = rdata_q;
	assign o_op_valid = op_valid_q;
	assign o_op_code = code_q;
	assign o_op_icache = icache_q;
	assign o_op_clean = clean_q;
	assign o_op_inval = inval_q;
	assign o_op_setway = setway_q;
	assign o_op_point_of_unification = unif_q;
	assign o_op_addr = addr_q;
	assign o_op_set = set_q;
	assign o_op_way = way_q;

	// ============================================================
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	a_unpriv_fault_answer:
	assert property (take && in_space && !i_priv |=> o_ack && o_bus_fault)
		else $error("unprivileged access not faulted");

	a_unpriv_no_op:
	assert property (take && in_space && !i_priv |=> !o_op_valid [*2])
		else $error("unprivileged access started an operation");

	a_icache_inv_all:
	assert property (take && i_priv && i_write && i_addr == cmo_pkg::CMO_ICACHE_INVALIDATE_ALL_ADDR
		|=> o_op_valid && o_op_icache && o_op_inval && o_op_point_of_unification && !o_op_setway)
		else $error("instruction invalidate all not issued");

	a_icache_inv_addr:
	assert property (take && i_priv && i_write && i_addr == cmo_pkg::CMO_ICACHE_INVALIDATE_BY_ADDR_ADDR
		|=> o_op_valid && o_op_icache && o_op_inval
		&& o_op_addr[31:LINE_BITS] == $past(i_wdata[31:LINE_BITS]))
		else $error("instruction invalidate by address wrong");

	// Any byte lane selects the word, so match on the word address
	a_dcache_inv_coh:
	assert property (take && i_priv && i_write
		&& i_addr[31:2] == cmo_pkg::CMO_DCACHE_INVALIDATE_BY_ADDR_ADDR[31:2]
		|=> o_op_valid && o_op_inval && !o_op_clean && !o_op_point_of_unification && !o_op_icache
		&& o_op_addr[31:LINE_BITS] == $past(i_wdata[31:LINE_BITS]))
		else $error("data invalidate by address wrong");

	a_dcache_inv_setway:
	assert property (take && i_priv && i_write && i_addr == cmo_pkg::CMO_DCACHE_INVALIDATE_BY_SETWAY_ADDR
		|=> o_op_valid && o_op_setway && o_op_inval && !o_op_clean
		&& o_op_set == $past(i_wdata[LINE_BITS +: SET_BITS]) && o_op_way == $past(i_wdata[31 -: WAY_BITS]))
		else $error("data invalidate by set and way wrong");

	a_dcache_clean_unif:
	assert property (take && i_priv && i_write && i_addr == cmo_pkg::CMO_DCACHE_MAINT_ADDR_UNIF_ADDR
		|=> o_op_valid && o_op_clean && !o_op_inval && o_op_point_of_unification)
		else $error("data clean to unification wrong");

	a_dcache_clean_coh:
	assert property (take && i_priv && i_write && i_addr == cmo_pkg::CMO_DCACHE_CLEAN_BY_ADDR_ADDR
		|=> o_op_valid && o_op_clean && !o_op_inval && !o_op_point_of_unification && !o_op_setway)
		else $error("data clean to coherency wrong");

	a_dcache_clean_setway:
	assert property (take && i_priv && i_write && i_addr == cmo_pkg::CMO_DCACHE_CLEAN_BY_SETWAY_ADDR
		|=> o_op_valid && o_op_setway && o_op_clean && !o_op_inval
		&& o_op_set == $past(i_wdata[LINE_BITS +: SET_BITS]) && o_op_way == $past(i_wdata[31 -: WAY_BITS]))
		else $error("data clean by set and way wrong");

	a_dcache_clean_inv:
	assert property (take && i_priv && i_write
		&& i_addr[31:2] == cmo_pkg::CMO_DCACHE_CLEAN_INVALIDATE_BY_ADDR_ADDR[31:2]
		|=> o_op_valid && o_op_clean && o_op_inval && !o_op_point_of_unification)
		else $error("data clean and invalidate wrong");

	a_reserved_no_op:
	assert property (take && i_priv && i_addr[31:2] == cmo_pkg::CMO_RESERVED_ADDR[31:2]
		|=> o_ack && !o_bus_fault && !o_op_valid)
		else $error("reserved word started an operation");

	a_read_no_op:
	assert property (take && i_priv && !i_write |=> o_ack && !o_op_valid ##1 !o_op_valid)
		else $error("read started an operation");

	a_op_held_stable:
	assert property (o_op_valid && !i_op_ready |=> o_op_valid && $stable(o_op_code) && !o_ack)
		else $error("operation dropped before taken");

	a_ack_after_take:
	assert property (o_op_valid && i_op_ready |=> o_ack && !o_op_valid ##1 !o_ack)
		else $error("store not answered after operation taken");

endmodule // cmo_top

// >>> tb/cmo_cache_model.sv
`timescale 1ns/1ps
// ============================================================
// Cache controller stand-in: takes a pending operation after a set wait
module cmo_cache_model (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_op_valid,
	input wire logic [3:0] i_delay,
	output logic o_op_ready,
	output logic [7:0] o_taken
);
	logic [3:0] wait_q;

	// Ready drops on the take edge, so a stale ready never takes the next operation
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			wait_q <= 4'h0;
			o_op_ready <= 1'b0;
			o_taken <= 8'h00;
		end else if (i_op_valid && o_op_ready) begin
			o_op_ready <= 1'b0;
			wait_q <= 4'h0;
			o_taken <= o_taken + 8'h01;
		end else if (i_op_valid) begin
			if (wait_q >= i_delay) begin
				o_op_ready <= 1'b1;
			end else begin
				wait_q <= wait_q + 4'h1; // Slow answer
			end
		end
	end
endmodule // cmo_cache_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Bench for the cache maintenance register port
module tb_top;
	typedef struct {
		logic wr, pr, flt, has_op;
		logic [31:0] addr, wdata, oaddr;
		cmo_pkg::cmo_op_e code;
		logic [4:0] flags;
		logic [3:0] dly;
	} cmo_row_s;

	logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_req = 1'b0, i_write = 1'b0, i_priv = 1'b0;
	logic [31:0] i_addr = 32'h0, i_wdata = 32'h0;
	logic o_ack, o_bus_fault, o_op_valid, o_op_icache, o_op_clean, o_op_inval, o_op_setway, o_op_unif, op_ready;
	logic [31:0] o_rdata, o_op_addr;
	cmo_pkg::cmo_op_e o_op_code;
	logic [6:0] o_op_set;
	logic [1:0] o_op_way;
	logic [3:0] dly = 4'h0;
	logic [7:0] taken, taken0;
	int miscompares = 0, samples_checked = 0, vcyc, i;
	logic seen_op, got_ack, c_flt;
	logic [31:0] c_rdata, c_addr, c_code;
	logic [4:0] c_flags;
	logic [8:0] c_sw;
	cmo_row_s rows[14];

	always #5 i_clk_sys = ~i_clk_sys;

	cmo_top DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req(i_req), .i_write(i_write), .i_priv(i_priv),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_op_ready(op_ready), .o_ack(o_ack), .o_bus_fault(o_bus_fault),
		.o_rdata(o_rdata), .o_op_valid(o_op_valid), .o_op_code(o_op_code), .o_op_icache(o_op_icache),
		.o_op_clean(o_op_clean), .o_op_inval(o_op_inval), .o_op_setway(o_op_setway),
		.o_op_point_of_unification(o_op_unif), .o_op_addr(o_op_addr), .o_op_set(o_op_set), .o_op_way(o_op_way));

	cmo_cache_model PEER (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_op_valid(o_op_valid), .i_delay(dly),
		.o_op_ready(op_ready), .o_taken(taken));

	// ============================================================
	// Comparison and verdict
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (exp !== got) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One access; poke sends a second request while the first is still in flight
	task automatic access(input logic wr, input logic pr, input logic [31:0] ad, input logic [31:0] wd,
		input logic poke);
		@(posedge i_clk_sys);
		i_req <= 1'b1;
		i_write <= wr;
		i_priv <= pr;
		i_addr <= ad;
		i_wdata <= wd;
		@(posedge i_clk_sys);
		i_req <= 1'b0;
		if (poke) begin
			@(posedge i_clk_sys);
			i_req <= 1'b1;
			i_addr <= cmo_pkg::CMO_ICACHE_INVALIDATE_ALL_ADDR;
			@(posedge i_clk_sys);
			i_req <= 1'b0;
		end
		seen_op = 1'b0;
		got_ack = 1'b0;
		vcyc = 0;
		for (int n = 0; n < 60 && !got_ack; n++) begin
			@(negedge i_clk_sys);
			if (o_op_valid === 1'b1) begin
				seen_op = 1'b1;
				vcyc++;
				c_code = 32'(o_op_code);
				c_flags = {o_op_icache, o_op_clean, o_op_inval, o_op_setway, o_op_unif};
				c_addr = o_op_addr;
				c_sw = {o_op_way, o_op_set};
			end
			if (o_ack === 1'b1) begin
				got_ack = 1'b1;
				c_flt = o_bus_fault;
				c_rdata = o_rdata;
			end
		end
		@(posedge i_clk_sys);
	endtask

	// ============================================================
	// Watchdog, far beyond the expected hundred or so cycles
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end

	// ============================================================
	// Main sequence: table rows, then reset and awkward cases
	initial begin
		// Flags are icache, clean, inval, setway, point of unification
		rows[0] = '{1, 1, 0, 1, 32'he000ef50, 32'hffffffff, 32'h0, cmo_pkg::CMO_OP_IC_INV_ALL, 5'b10101, 0};
		rows[1] = '{1, 1, 0, 1, 32'he000ef58, 32'h1234567f, 32'h12345660, cmo_pkg::CMO_OP_IC_INV_ADDR, 5'b10101, 3};
		rows[2] = '{1, 1, 0, 1, 32'he000ef5e, 32'h8000003f, 32'h80000020, cmo_pkg::CMO_OP_DC_INV_ADDR, 5'b00100, 0};
		rows[3] = '{1, 1, 0, 1, 32'he000ef60, 32'hc0000fe0, 32'hc0000fe0, cmo_pkg::CMO_OP_DC_INV_SW, 5'b00110, 2};
		rows[4] = '{1, 1, 0, 1, 32'he000ef64, 32'h0000101f, 32'h00001000, cmo_pkg::CMO_OP_DC_CLEAN_UNIF, 5'b01001, 0};
		rows[5] = '{1, 1, 0, 1, 32'he000ef68, 32'hdeadbeef, 32'hdeadbee0, cmo_pkg::CMO_OP_DC_CLEAN_ADDR, 5'b01000, 5};
		rows[6] = '{1, 1, 0, 1, 32'he000ef6c, 32'h40000020, 32'h40000020, cmo_pkg::CMO_OP_DC_CLEAN_SW, 5'b01010, 1};
		rows[7] = '{1, 1, 0, 1, 32'he000ef73, 32'h55555555, 32'h55555540, cmo_pkg::CMO_OP_DC_CLEAN_INV_ADDR, 5'b01100, 0};
		rows[8] = '{1, 1, 0, 0, 32'he000ef54, 32'hffffffff, 32'h0, cmo_pkg::CMO_OP_NONE, 5'b0, 0};
		rows[9] = '{1, 0, 1, 0, 32'he000ef68, 32'h00000100, 32'h0, cmo_pkg::CMO_OP_NONE, 5'b0, 0};
		rows[10] = '{0, 0, 1, 0, 32'he000ef50, 32'h0, 32'h0, cmo_pkg::CMO_OP_NONE, 5'b0, 0};
		rows[11] = '{1, 0, 1, 0, 32'he000ef54, 32'h0, 32'h0, cmo_pkg::CMO_OP_NONE, 5'b0, 0};
		rows[12] = '{0, 1, 0, 0, 32'he000ef5c, 32'h0, 32'h0, cmo_pkg::CMO_OP_NONE, 5'b0, 0};
		rows[13] = '{1, 1, 0, 0, 32'he000ef74, 32'h12345678, 32'h0, cmo_pkg::CMO_OP_NONE, 5'b0, 0};
		repeat (10) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		@(negedge i_clk_sys);
		// Flags and read data checked apart, so no bit is cut away
		chk("reset answer", 32'h0, 32'({o_ack, o_bus_fault, o_op_valid}));
		chk("reset rdata", 32'h0, o_rdata);
		chk("reset fields", 32'h0, 32'({o_op_icache, o_op_clean, o_op_inval, o_op_setway, o_op_unif, o_op_set, o_op_way}));
		chk("reset addr", 32'h0, o_op_addr);
		chk("reset code", 32'(cmo_pkg::CMO_OP_NONE), 32'(o_op_code));
		for (i = 0; i < 14; i++) begin
			dly <= rows[i].dly;
			taken0 = taken;
			access(rows[i].wr, rows[i].pr, rows[i].addr, rows[i].wdata, 1'b0);
			chk("ack", 32'h1, 32'(got_ack));
			chk("fault", 32'(rows[i].flt), 32'(c_flt));
			chk("rdata", 32'h0, c_rdata);
			chk("op seen", 32'(rows[i].has_op), 32'(seen_op));
			chk("ops taken", 32'(rows[i].has_op), 32'(taken - taken0));
			if (rows[i].has_op) begin
				chk("code", 32'(rows[i].code), c_code);
				chk("flags", 32'(rows[i].flags), 32'(c_flags));
				chk("op addr", rows[i].oaddr, c_addr);
				chk("set way", 32'({rows[i].wdata[31:30], rows[i].wdata[11:5]}), 32'(c_sw));
				chk("wait", 32'(vcyc > rows[i].dly), 32'h1);
			end
		end
		// Second request during a stalled operation is ignored
		dly <= 4'h8;
		taken0 = taken;
		access(1'b1, 1'b1, cmo_pkg::CMO_DCACHE_CLEAN_BY_ADDR_ADDR, 32'h00000040, 1'b1);
		chk("busy code", 32'(cmo_pkg::CMO_OP_DC_CLEAN_ADDR), c_code);
		repeat (8) @(posedge i_clk_sys);
		chk("busy taken", 32'h1, 32'(taken - taken0));
		// Reset in the middle of a pending operation clears everything
		dly <= 4'hf;
		@(posedge i_clk_sys);
		i_req <= 1'b1;
		i_addr <= cmo_pkg::CMO_DCACHE_INVALIDATE_BY_SETWAY_ADDR;
		@(posedge i_clk_sys);
		i_req <= 1'b0;
		repeat (3) @(negedge i_clk_sys);
		chk("pending", 32'h1, 32'(o_op_valid));
		@(posedge i_clk_sys);
		i_resetn <= 1'b0;
		@(posedge i_clk_sys);
		@(negedge i_clk_sys);
		chk("mid reset", 32'h0, {o_ack, o_op_valid, o_op_addr[29:0]});
		chk("mid code", 32'(cmo_pkg::CMO_OP_NONE), 32'(o_op_code));
		@(posedge i_clk_sys);
		i_resetn <= 1'b1;
		dly <= 4'h0;
		access(1'b1, 1'b1, cmo_pkg::CMO_ICACHE_INVALIDATE_ALL_ADDR, 32'h0, 1'b0);
		chk("after reset ack", 32'h1, 32'(got_ack));
		chk("after reset", 32'(cmo_pkg::CMO_OP_IC_INV_ALL), c_code);
		wrap_up();
	end
endmodule // tb_top
